// ---- pmmp_pkg.sv ----
/*
  Constants, types and state codes shared by the management port files.
  Assumes the importing files run on a 125 MHz system clock.
*/
`default_nettype none
package pmmp_pkg;

  // ---------------------------------------------------------------
  // Two-wire addressing and memory layout
  // ---------------------------------------------------------------
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam int MEM_BYTES = 256;
  localparam logic [7:0] USER_BASE = 8'h80;
  localparam logic [3:0] MON_PAGE = 4'h6;
  localparam logic [7:0] ALARM_ADDR_HI = 8'h70;
  localparam logic [7:0] ALARM_ADDR_LO = 8'h71;
  localparam logic [7:0] WARN_ADDR_HI = 8'h74;
  localparam logic [7:0] WARN_ADDR_LO = 8'h75;
  localparam int NUM_MON = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MCLK_MHZ = 125;
  localparam int TX_OFF_MAX_NS = 10000;
  localparam int TX_OFF_MAX_CYC = TX_OFF_MAX_NS * MCLK_MHZ / 1000;

  // ---------------------------------------------------------------
  // Types and reset values
  // ---------------------------------------------------------------
  // Channels: 0 temperature, 1 bias, 2 tx power, 3 rx power, 4 supply
  typedef logic [NUM_MON-1:0][15:0] pmmp_mon_t;

  typedef struct packed {
    pmmp_mon_t hi_alarm;
    pmmp_mon_t lo_alarm;
    pmmp_mon_t hi_warn;
    pmmp_mon_t lo_warn;
  } pmmp_limits_t;

  typedef struct packed {
    pmmp_mon_t value;
    logic [15:0] alarm;
    logic [15:0] warn;
  } pmmp_snap_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sig_det;
    logic tx_dis;
    logic laser_fault;
    logic light;
  } pmmp_pins_t;

  localparam pmmp_limits_t LIMITS_DEFAULT = '{hi_alarm: '1, lo_alarm: '0,
                                              hi_warn: '1, lo_warn: '0};
  localparam pmmp_snap_t SNAP_RESET = '0;
  // Identification content; all-zero default is arbitrary
  localparam logic [8*MEM_BYTES-1:0] ID_CONTENT_DEFAULT = '0;
  localparam pmmp_pins_t PINS_RESET = '{scl: 1'b1, sda: 1'b1, sig_det: 1'b0,
                                        tx_dis: 1'b1, laser_fault: 1'b0,
                                        light: 1'b0};

  typedef enum logic [8:0] {
    ST_ADDR      = 9'h001,
    ST_ADDR_ACK  = 9'h002,
    ST_PTR       = 9'h004,
    ST_PTR_ACK   = 9'h008,
    ST_WRITE     = 9'h010,
    ST_WRITE_ACK = 9'h020,
    ST_READ      = 9'h040,
    ST_READ_ACK  = 9'h080,
    ST_IGNORE    = 9'h100
  } pmmp_link_state_t;

endpackage
`default_nettype wire

// ---- pmmp_sync.sv ----
/*
  Two-flop level synchroniser for a group of signals.
  Assumes the inputs are quasi-static relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pmmp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ---------------------------------------------------------------
  // Two stages, the first read only by the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule // pmmp_sync
`default_nettype wire

// ---- pmmp_mgmt_port.sv ----
/*
  Management side of a pluggable transceiver: two-wire target serving an
  identification memory and a diagnostic page, plus sideband pins.
  Assumes an external pull-up on the data and clock wires, a host that
  drives the serial clock, and calibrated readings from same-clock logic.
*/
// Behaviour
// - 256-byte identification memory at address A0h
// - Diagnostic page answers at separate address A2h
// - Identification memory holds readable capability data
// - Capture on rising edge; protected bytes unchanged
// - Outgoing data bits change on falling edge
// - Bidirectional data; detect start and stop
// - Byte words, single or auto-incrementing access
// - Page shows five live monitor readings
// - Flags set when reading leaves normal range
// - Reported values already calibrated, no coefficients
// - Signal-loss output low normally, high on loss
// - Receive data valid while signal present
// - Optical output off within 10 us
// - Transmitter off while disable high or open
// - Fault output high on laser fault
// - Presence pin held low
`timescale 1ns/1ps
`default_nettype none
module pmmp_mgmt_port
  import pmmp_pkg::*;
#(
  parameter logic [8*pmmp_pkg::MEM_BYTES-1:0] ID_CONTENT = pmmp_pkg::ID_CONTENT_DEFAULT,
  parameter pmmp_pkg::pmmp_limits_t LIMITS = pmmp_pkg::LIMITS_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mgmt_clock_pin,
  input wire logic mgmt_data_pin_in,
  output logic mgmt_data_pin_out,
  output logic mgmt_data_pin_oe_n,
  input wire logic rx_signal_detect,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_in,
  input wire logic laser_light_detect,
  input wire pmmp_pkg::pmmp_mon_t mon_value,
  output logic signal_loss_flag,
  output logic rx_data_valid,
  output logic laser_enable,
  output logic tx_fault,
  output logic module_present_pin
);
  import pmmp_pkg::*;

  localparam int OFF_W = $clog2(TX_OFF_MAX_CYC + 1);
  localparam logic [OFF_W-1:0] OFF_MAX = OFF_W'(TX_OFF_MAX_CYC);

  // ---------------------------------------------------------------
  // System clock domain: pin synchronisers
  // ---------------------------------------------------------------
  pmmp_pins_t pins_raw;
  pmmp_pins_t pins_s;

  // Gather outside pins for the synchroniser
  assign pins_raw = '{scl: mgmt_clock_pin, sda: mgmt_data_pin_in,
                      sig_det: rx_signal_detect, tx_dis: tx_disable_pin,
                      laser_fault: laser_fault_in, light: laser_light_detect};

  pmmp_sync #(
    .W($bits(pmmp_pins_t)),
    .RST_VAL(PINS_RESET)
  ) u_pin_sync (
    .clk(mclk),
    .rst(rst),
    .d(pins_raw),
    .q(pins_s)
  );

  // ---------------------------------------------------------------
  // System clock domain: start and stop detection
  // ---------------------------------------------------------------
  logic sda_prev_reg;
  logic frame_active_reg;
  logic start_hold_reg;
  logic link_clr_reg;
  logic ptr_clr_reg;
  logic start_seen;
  logic stop_seen;

  // Data edges while the clock is high frame a transfer
  assign start_seen = pins_s.scl & sda_prev_reg & ~pins_s.sda;
  assign stop_seen = pins_s.scl & ~sda_prev_reg & pins_s.sda;

  // Previous data level for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_prev_reg <= 1'b1;
    end else begin
      sda_prev_reg <= pins_s.sda;
    end
  end

  // Frame open from start to stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_active_reg <= 1'b0;
    end else if (start_seen) begin
      frame_active_reg <= 1'b1;
    end else if (stop_seen) begin
      frame_active_reg <= 1'b0;
    end
  end

  // Start held until the clock falls, so the link restarts cleanly
  always_ff @(posedge mclk) begin
    if (rst) begin
      start_hold_reg <= 1'b0;
    end else if (start_seen) begin
      start_hold_reg <= 1'b1;
    end else if (!pins_s.scl) begin
      start_hold_reg <= 1'b0;
    end
  end

  // Link clear: reset, idle bus or fresh start; released with clock low
  always_ff @(posedge mclk) begin
    if (rst) begin
      link_clr_reg <= 1'b1;
      ptr_clr_reg <= 1'b1;
    end else begin
      link_clr_reg <= start_hold_reg | start_seen | ~frame_active_reg;
      ptr_clr_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // System clock domain: monitors, flags and snapshot
  // ---------------------------------------------------------------
  logic [15:0] alarm_now;
  logic [15:0] warn_now;
  pmmp_snap_t snap_reg;

  // Compare each reading with its factory limits
  always_comb begin
    alarm_now = '0;
    warn_now = '0;
    for (int k = 0; k < NUM_MON; k++) begin
      alarm_now[2*k+1] = mon_value[k] > LIMITS.hi_alarm[k];
      alarm_now[2*k] = mon_value[k] < LIMITS.lo_alarm[k];
      warn_now[2*k+1] = mon_value[k] > LIMITS.hi_warn[k];
      warn_now[2*k] = mon_value[k] < LIMITS.lo_warn[k];
    end
  end

  // Snapshot frozen for the whole frame, so the link reads stable words
  always_ff @(posedge mclk) begin
    if (rst) begin
      snap_reg <= SNAP_RESET;
    end else if (!frame_active_reg && !start_seen) begin
      snap_reg.value <= mon_value;
      snap_reg.alarm <= alarm_now;
      snap_reg.warn <= warn_now;
    end
  end

  // ---------------------------------------------------------------
  // System clock domain: sideband pins
  // ---------------------------------------------------------------
  logic [OFF_W-1:0] off_cnt_reg;
  logic off_timeout;

  assign off_timeout = off_cnt_reg == OFF_MAX;

  // Light still seen too long after disable counts as a fault
  always_ff @(posedge mclk) begin
    if (rst) begin
      off_cnt_reg <= '0;
    end else if (pins_s.tx_dis && pins_s.light) begin
      if (!off_timeout) begin
        off_cnt_reg <= off_cnt_reg + 1'b1;
      end
    end else begin
      off_cnt_reg <= '0;
    end
  end

  // Transmitter control and status outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      laser_enable <= 1'b0;
      tx_fault <= 1'b0;
      signal_loss_flag <= 1'b1;
      rx_data_valid <= 1'b0;
      module_present_pin <= 1'b0;
    end else begin
      laser_enable <= ~pins_s.tx_dis;
      tx_fault <= pins_s.laser_fault | off_timeout;
      signal_loss_flag <= ~pins_s.sig_det;
      rx_data_valid <= pins_s.sig_det;
      module_present_pin <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Link clock domain: target state machine
  // ---------------------------------------------------------------
  pmmp_link_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic dev_diag_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] ptr_reg;
  logic [7:0] rd_byte;
  logic [7:0] rx_byte;
  logic [7:0] user_ram [0:MEM_BYTES/2-1];
  logic byte_end;
  logic ram_we;
  logic tx_load;

  assign rx_byte = {shift_reg, mgmt_data_pin_in};
  assign byte_end = bit_cnt_reg == 3'h7;
  assign ram_we = state_reg == ST_WRITE && byte_end && dev_diag_reg
                  && ptr_reg >= USER_BASE;
  assign tx_load = (state_reg == ST_ADDR_ACK && shift_reg[0])
                   || (state_reg == ST_READ_ACK && !mgmt_data_pin_in);

  // Read mux over both memories
  always_comb begin
    rd_byte = 8'h00;
    if (!dev_diag_reg) begin
      rd_byte = ID_CONTENT[{ptr_reg, 3'h0} +: 8];
    end else if (ptr_reg >= USER_BASE) begin
      rd_byte = user_ram[ptr_reg[6:0]];
    end else if (ptr_reg[7:4] == MON_PAGE && ptr_reg[3:1] < 3'(NUM_MON)) begin
      rd_byte = ptr_reg[0] ? snap_reg.value[ptr_reg[3:1]][7:0]
                           : snap_reg.value[ptr_reg[3:1]][15:8];
    end else if (ptr_reg == ALARM_ADDR_HI) begin
      rd_byte = snap_reg.alarm[15:8];
    end else if (ptr_reg == ALARM_ADDR_LO) begin
      rd_byte = snap_reg.alarm[7:0];
    end else if (ptr_reg == WARN_ADDR_HI) begin
      rd_byte = snap_reg.warn[15:8];
    end else if (ptr_reg == WARN_ADDR_LO) begin
      rd_byte = snap_reg.warn[7:0];
    end
  end

  // Bit capture and sequencing on the rising clock edge
  always_ff @(posedge mgmt_clock_pin or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      dev_diag_reg <= 1'b0;
      tx_byte_reg <= 8'hff;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          shift_reg <= rx_byte[6:0];
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (byte_end) begin
            dev_diag_reg <= rx_byte[7:1] == DIAG_DEV_ADDR;
            if (rx_byte[7:1] == ID_DEV_ADDR || rx_byte[7:1] == DIAG_DEV_ADDR) begin
              state_reg <= ST_ADDR_ACK;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt_reg <= 3'h0;
          // Direction bit low asks for a write, high for a read
          if (!shift_reg[0]) begin
            state_reg <= ST_PTR;
          end else begin
            state_reg <= ST_READ;
            tx_byte_reg <= rd_byte;
          end
        end
        ST_PTR: begin
          shift_reg <= rx_byte[6:0];
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (byte_end) begin
            state_reg <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK: begin
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          shift_reg <= rx_byte[6:0];
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (byte_end) begin
            state_reg <= ST_WRITE_ACK;
          end
        end
        ST_WRITE_ACK: begin
          state_reg <= ST_WRITE;
        end
        ST_READ: begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (byte_end) begin
            state_reg <= ST_READ_ACK;
          end
        end
        ST_READ_ACK: begin
          bit_cnt_reg <= 3'h0;
          if (!mgmt_data_pin_in) begin
            state_reg <= ST_READ;
            tx_byte_reg <= rd_byte;
          end else begin
            state_reg <= ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          state_reg <= ST_IGNORE;
        end
        default: begin
          state_reg <= ST_IGNORE;
        end
      endcase
    end
  end

  // Shared byte pointer survives repeated starts for random reads
  always_ff @(posedge mgmt_clock_pin or posedge ptr_clr_reg) begin
    if (ptr_clr_reg) begin
      ptr_reg <= 8'h00;
    end else if (state_reg == ST_PTR && byte_end) begin
      ptr_reg <= rx_byte;
    end else if ((state_reg == ST_WRITE && byte_end) || tx_load) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // Writable user area of the diagnostic page
  always_ff @(posedge mgmt_clock_pin) begin
    if (ram_we) begin
      user_ram[ptr_reg[6:0]] <= rx_byte;
    end
  end

  // ---------------------------------------------------------------
  // Link clock domain: data line drive on the falling edge
  // ---------------------------------------------------------------
  logic drive_ack;
  logic drive_bit;

  assign drive_ack = state_reg == ST_ADDR_ACK || state_reg == ST_PTR_ACK
                     || state_reg == ST_WRITE_ACK;
  assign drive_bit = state_reg == ST_READ && !tx_byte_reg[3'h7 - bit_cnt_reg];

  // Open-drain drive: only ever pull low, released when cleared
  always_ff @(negedge mgmt_clock_pin or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      mgmt_data_pin_oe_n <= 1'b1;
      mgmt_data_pin_out <= 1'b0;
    end else begin
      mgmt_data_pin_oe_n <= ~(drive_ack | drive_bit);
      mgmt_data_pin_out <= 1'b0;
    end
  end

endmodule // pmmp_mgmt_port
`default_nettype wire

// ---- pmmp_host_model.sv ----
/*
  Host controller model: two-wire master driving the serial clock.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module pmmp_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // --------------------------------------------------------------
  // Bus cycles, 160 ns clock period, clock idle high between frames
  // --------------------------------------------------------------
  localparam realtime HALF = 80;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while clock high
  task automatic start();
    #10 sda_low = 1'b0;
    #(HALF) scl = 1'b1;
    #(HALF) sda_low = 1'b1;
    #(HALF) scl = 1'b0;
  endtask
  // Stop: data rises while clock high, clock then stands
  task automatic stop();
    #10 sda_low = 1'b1;
    #(HALF) scl = 1'b1;
    #(HALF) sda_low = 1'b0;
    #(HALF);
  endtask
  // One bit: set data in low phase, sample at end of high phase
  task automatic bit_io(input logic b, output logic r);
    #10 sda_low = !b;
    #(HALF - 10) scl = 1'b1;
    #(HALF) r = sda;
    scl = 1'b0;
  endtask
  // Byte out MSB first, then target acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in MSB first, then host acknowledge or not
  task automatic rd_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // pmmp_host_model
`default_nettype wire

// ---- pmmp_mgmt_port_monitor.sv ----
/*
  Checker for the data pin drive and sideband outputs.
  Assumes it is bound to pmmp_mgmt_port; mclk domain only.
*/
`timescale 1ns/1ps
`default_nettype none
module pmmp_mgmt_port_monitor
  import pmmp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic mgmt_clock_pin,
  input wire logic mgmt_data_pin_out,
  input wire logic mgmt_data_pin_oe_n,
  input wire logic rx_signal_detect,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_in,
  input wire logic laser_light_detect,
  input wire logic signal_loss_flag,
  input wire logic rx_data_valid,
  input wire logic laser_enable,
  input wire logic tx_fault,
  input wire logic module_present_pin
);
  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (rst);
  int lit_cnt;
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  // Cycles with disable and light both high
  always_ff @(posedge mclk) begin
    if (rst || !(tx_disable_pin && laser_light_detect)) lit_cnt <= 0;
    else if (lit_cnt < 4000) lit_cnt <= lit_cnt + 1;
  end
  a_presence_low: assert property (
    module_present_pin == 1'b0) else $error("presence pin not low");
  a_open_drain: assert property (
    mgmt_data_pin_out == 1'b0) else $error("data pin driven high");
  a_drive_low_phase: assert property (
    $fell(mgmt_data_pin_oe_n) |-> !mgmt_clock_pin) else $error("drive began in high phase");
  a_steady_high: assert property (
    mgmt_clock_pin && $past(mgmt_clock_pin) |-> $stable(mgmt_data_pin_oe_n))
    else $error("data drive moved in high phase");
  a_loss_clears: assert property (
    $rose(rx_signal_detect) |-> ##3 !signal_loss_flag) else $error("loss flag stuck high");
  a_loss_sets: assert property (
    $fell(rx_signal_detect) |-> ##3 signal_loss_flag) else $error("loss flag stuck low");
  a_valid_pair: assert property (
    rx_data_valid != signal_loss_flag) else $error("valid disagrees with loss");
  a_laser_off: assert property (
    $rose(tx_disable_pin) |-> ##3 !laser_enable) else $error("laser not turned off");
  a_laser_held: assert property (
    tx_disable_pin [*4] |-> !laser_enable) else $error("laser on while disabled");
  a_laser_on: assert property (
    $fell(tx_disable_pin) |-> ##3 laser_enable) else $error("laser not turned on");
  a_fault_shown: assert property (
    $rose(laser_fault_in) |-> ##3 tx_fault) else $error("fault not reported");
  a_offtime_fault: assert property (
    lit_cnt > TX_OFF_MAX_CYC + 6 |-> tx_fault) else $error("light persists, no fault");
endmodule // pmmp_mgmt_port_monitor
bind pmmp_mgmt_port pmmp_mgmt_port_monitor pmmp_mgmt_port_monitor_i (
  .mclk(mclk), .rst(rst), .mgmt_clock_pin(mgmt_clock_pin),
  .mgmt_data_pin_out(mgmt_data_pin_out), .mgmt_data_pin_oe_n(mgmt_data_pin_oe_n),
  .rx_signal_detect(rx_signal_detect), .tx_disable_pin(tx_disable_pin),
  .laser_fault_in(laser_fault_in), .laser_light_detect(laser_light_detect),
  .signal_loss_flag(signal_loss_flag), .rx_data_valid(rx_data_valid),
  .laser_enable(laser_enable), .tx_fault(tx_fault), .module_present_pin(module_present_pin)
);
`default_nettype wire

// ---- pmmp_mgmt_port_tb_top.sv ----
/*
  Self-checking bench for the management port.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module pmmp_mgmt_port_tb_top;
  import pmmp_pkg::*;
  // Identification bytes: byte n holds n xor 3c
  function automatic logic [8*MEM_BYTES-1:0] id_gen();
    logic [8*MEM_BYTES-1:0] r;
    for (int n = 0; n < MEM_BYTES; n++) r[8*n +: 8] = 8'(n) ^ 8'h3c;
    return r;
  endfunction
  localparam logic [8*MEM_BYTES-1:0] ID_FILL = id_gen();
  localparam pmmp_limits_t LIM = '{hi_alarm: {{4{16'hffff}}, 16'h1000}, lo_alarm: '0,
                                   hi_warn: '1, lo_warn: {16'h8000, {4{16'h0000}}}};
  localparam pmmp_mon_t MON = {16'h7000, 16'h9abc, 16'h5678, 16'h1234, 16'h2000};
  logic mclk, rst, mgmt_clock_pin, host_low, mgmt_data_pin_in, mgmt_data_pin_out;
  logic mgmt_data_pin_oe_n, rx_signal_detect, tx_disable_pin, laser_fault_in;
  logic laser_light_detect, signal_loss_flag, rx_data_valid, laser_enable, tx_fault;
  logic module_present_pin;
  pmmp_mon_t mon_value;
  int num_errors = 0;
  int checks_done = 0;
  // --------------------------------------------------------------
  // Clock, wire, instances
  // --------------------------------------------------------------
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  // Pull-up wire, low if either party pulls
  assign mgmt_data_pin_in = !(host_low || !mgmt_data_pin_oe_n);
  pmmp_host_model pmmp_host_model_i (.scl(mgmt_clock_pin), .sda_low(host_low),
                                     .sda(mgmt_data_pin_in));
  pmmp_mgmt_port #(.ID_CONTENT(ID_FILL), .LIMITS(LIM)) pmmp_mgmt_port_i (
    .mclk(mclk), .rst(rst), .mgmt_clock_pin(mgmt_clock_pin),
    .mgmt_data_pin_in(mgmt_data_pin_in), .mgmt_data_pin_out(mgmt_data_pin_out),
    .mgmt_data_pin_oe_n(mgmt_data_pin_oe_n), .rx_signal_detect(rx_signal_detect),
    .tx_disable_pin(tx_disable_pin), .laser_fault_in(laser_fault_in),
    .laser_light_detect(laser_light_detect), .mon_value(mon_value),
    .signal_loss_flag(signal_loss_flag), .rx_data_valid(rx_data_valid),
    .laser_enable(laser_enable), .tx_fault(tx_fault), .module_present_pin(module_present_pin));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic send(input logic [7:0] d, input logic want);
    logic a;
    pmmp_host_model_i.wr_byte(d, a);
    check(16'(a), 16'(want));
  endtask
  task automatic begin_frame(input logic [7:0] a, input logic want);
    @(negedge mclk);
    #1.7;
    pmmp_host_model_i.start();
    send(a, want);
  endtask
  task automatic fetch(input logic [7:0] exp, input logic more);
    logic [7:0] d;
    pmmp_host_model_i.rd_byte(d, more);
    check(16'(d), 16'(exp));
  endtask
  // Expected diagnostic byte: readings, alarm 0002, warn 0100, else 0
  function automatic logic [7:0] exp_diag(input int a);
    logic [15:0] v;
    v = 16'h0000;
    if (a >= 'h60 && a < 'h6a) v = MON[(a - 'h60) / 2];
    if (a == 'h70 || a == 'h71) v = 16'h0002;
    if (a == 'h74 || a == 'h75) v = 16'h0100;
    return a[0] ? v[7:0] : v[15:8];
  endfunction
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_sideband();
    rx_signal_detect = 1'b1;
    settle(4);
    check(16'(signal_loss_flag), 16'h0000);
    check(16'(rx_data_valid), 16'h0001);
    rx_signal_detect = 1'b0;
    settle(4);
    check(16'(signal_loss_flag), 16'h0001);
    tx_disable_pin = 1'b0;
    settle(4);
    check(16'(laser_enable), 16'h0001);
    tx_disable_pin = 1'b1;
    settle(4);
    check(16'(laser_enable), 16'h0000);
    laser_fault_in = 1'b1;
    settle(4);
    check(16'(tx_fault), 16'h0001);
    laser_fault_in = 1'b0;
    settle(4);
    check(16'(tx_fault), 16'h0000);
  endtask
  task automatic t_offtime();
    laser_light_detect = 1'b1;
    settle(TX_OFF_MAX_CYC - 20);
    check(16'(tx_fault), 16'h0000);
    settle(40);
    check(16'(tx_fault), 16'h0001);
    laser_light_detect = 1'b0;
    settle(4);
    check(16'(tx_fault), 16'h0000);
  endtask
  task automatic t_user_ram();
    begin_frame(8'ha2, 1'b1);
    send(USER_BASE, 1'b1);
    send(8'h5a, 1'b1);
    send(8'hc3, 1'b1);
    pmmp_host_model_i.stop();
    begin_frame(8'ha2, 1'b1);
    send(USER_BASE, 1'b1);
    pmmp_host_model_i.start();
    send(8'ha3, 1'b1);
    fetch(8'h5a, 1'b1);
    fetch(8'hc3, 1'b0);
    pmmp_host_model_i.stop();
  endtask
  task automatic t_id_memory();
    begin_frame(8'ha0, 1'b1);
    send(8'hfe, 1'b1);
    send(8'h00, 1'b1);
    pmmp_host_model_i.stop();
    begin_frame(8'ha0, 1'b1);
    send(8'hfe, 1'b1);
    pmmp_host_model_i.start();
    send(8'ha1, 1'b1);
    for (int i = 0; i < 3; i++) fetch(8'(8'hfe + i) ^ 8'h3c, i < 2);
    pmmp_host_model_i.stop();
  endtask
  task automatic t_foreign();
    begin_frame(8'ha4, 1'b0);
    send(8'h00, 1'b0);
    pmmp_host_model_i.stop();
    begin_frame(8'h40, 1'b0);
    pmmp_host_model_i.stop();
  endtask
  task automatic t_monitor();
    begin_frame(8'ha2, 1'b1);
    send(8'h60, 1'b1);
    pmmp_host_model_i.start();
    send(8'ha3, 1'b1);
    for (int a = 'h60; a <= 'h75; a++) fetch(exp_diag(a), a < 'h75);
    pmmp_host_model_i.stop();
  endtask
  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rx_signal_detect = 1'b0;
    tx_disable_pin = 1'b1;
    laser_fault_in = 1'b0;
    laser_light_detect = 1'b0;
    mon_value = MON;
    settle(5);
    check(16'(module_present_pin), 16'h0000);
    check(16'(signal_loss_flag), 16'h0001);
    check(16'(laser_enable), 16'h0000);
    rst = 1'b0;
    settle(8);
    t_sideband();
    t_offtime();
    t_user_ram();
    t_id_memory();
    t_foreign();
    t_monitor();
    conclude();
  end
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule // pmmp_mgmt_port_tb_top
`default_nettype wire
